/* File: core/dsadc_pkg.sv */
// Constants, types and register map of the dual-slope converter sequencer.
`default_nettype none
package dsadc_pkg;
    // Clock and external gate timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int GATE_MIN_NS = 300;
    // A start pulse must last more than the minimum, so one cycle is added.
    localparam logic [7:0] GATE_MIN_CYC = 8'(GATE_MIN_NS / CLK_PERIOD_NS + 1);

    // Measurement cycle lengths in clocks (the DEF constants are defaults of the top parameters).
    localparam int CNT_W = 16;
    localparam logic [15:0] DEF_CYCLE_CLOCKS = 16'h9c42;
    localparam logic [15:0] DEF_AUTO_ZERO_CLOCKS = 16'h2711;
    localparam logic [15:0] DEF_INTEGRATE_CLOCKS = 16'h2710;
    localparam logic [15:0] DEF_FULL_SCALE = 16'h4e20;
    localparam logic [15:0] DEF_OVER_ZERO_CLOCKS = 16'h1838;
    localparam logic [15:0] INT_ZERO_CLOCKS = 16'h00c8;
    localparam logic [15:0] UNDER_LIMIT = 16'h0708;

    // Digit scan timing.
    localparam int DIGITS = 5;
    localparam logic [2:0] MSD_IDX = 3'h4;
    localparam logic [2:0] LSD_IDX = 3'h0;
    localparam logic [7:0] MSD_CLOCKS = 8'hc9;
    localparam logic [7:0] DIGIT_CLOCKS = 8'hc8;
    localparam logic [7:0] MSD_STROBE_AT = 8'h65;
    localparam logic [7:0] DIGIT_STROBE_AT = 8'h64;
    localparam logic [3:0] BCD_NINE = 4'h9;

    // APB register map.
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_RESULT = 12'h008;
    localparam int CTRL_PIN_BIT = 0;
    localparam logic CTRL_RESET = 1'h0;

    // Measurement phases.
    typedef enum logic [2:0] {
        PH_HOLD = 3'b000,
        PH_AZ = 3'b001,
        PH_INT = 3'b010,
        PH_DEINT = 3'b011,
        PH_IZ = 3'b100
    } phase_type;

    // Analog switch network controls, one per phase other than hold.
    typedef struct packed {
        logic auto_zero;
        logic signal_int;
        logic ref_int;
        logic int_zero;
    } switch_type;
endpackage
`default_nettype wire

/* File: core/dsadc_sequencer.sv */
// Digital sequencer of a dual-slope converter with multiplexed BCD output and APB registers.
//
// Implementation choices: the placing of the registers and register access over APB.
`default_nettype none
// Functional notes
// RULE1: Phases run auto zero, integrate, deintegrate, zero.
// RULE2: Integrator zero lasts 200 clocks, 6200 on overrange.
// RULE3: Unconnected gate counts as high.
// RULE4: Gate high converts continuously, period 40002 clocks.
// RULE5: Gate low finishes cycle then holds result.
// RULE6: Gate pulse over 300 ns starts one cycle.
// RULE7: Pulses ignored until running cycle finishes.
// RULE8: Started cycle opens with 10001-clock auto zero.
// RULE9: Five latch pulses per cycle inside selects.
// RULE10: Most significant select 201 clocks, pulse at 101.
// RULE11: Other selects 200 clocks, pulse at 100.
// RULE12: Scan repeats; latch pulses only after measurements.
// RULE13: Busy spans integrate until after zero crossing.
// RULE14: Busy returns low after overrange too.
// RULE15: Display latches load first clock after busy.
// RULE16: Overrange when deintegration exceeds 20000 clocks.
// RULE17: Overrange set at busy fall, cleared deintegrate.
// RULE18: Underrange when result at most 1800 counts.
// RULE19: Sign high for positive, valid from deintegrate.
// RULE20: Overrange blanks selects until next deintegrate.
// RULE21: BCD data change together with selects.
// RULE22: Overrange forces BCD data to zero.
// RULE23: Comparator sampled each clock; crossing ends deintegrate.
// RULE24: Receiver latches digit at latch pulse end.
module dsadc_sequencer #(
    parameter logic [15:0] CYCLE_CLOCKS = dsadc_pkg::DEF_CYCLE_CLOCKS,
    parameter logic [15:0] AUTO_ZERO_CLOCKS = dsadc_pkg::DEF_AUTO_ZERO_CLOCKS,
    parameter logic [15:0] INTEGRATE_CLOCKS = dsadc_pkg::DEF_INTEGRATE_CLOCKS,
    parameter logic [15:0] FULL_SCALE = dsadc_pkg::DEF_FULL_SCALE,
    parameter logic [15:0] OVER_ZERO_CLOCKS = dsadc_pkg::DEF_OVER_ZERO_CLOCKS
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_conversion_gate,
    input wire logic i_comparator,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [dsadc_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    output dsadc_pkg::switch_type o_switches,
    output logic o_busy,
    output logic o_input_above_full_scale,
    output logic o_input_below_tenth_scale,
    output logic o_sign_flag,
    output logic [dsadc_pkg::DIGITS-1:0] o_digit_select,
    output logic [3:0] o_bcd,
    output logic o_digit_latch_pulse_n
);
    import dsadc_pkg::*;

    phase_type phase, next_phase;
    logic [15:0] ph_cnt, next_ph_cnt, el_cnt, next_el_cnt, az_len, next_az_len;
    logic [15:0] bin_cnt, next_bin_cnt;
    logic [7:0] gate_cnt, next_gate_cnt;
    logic busy, next_busy, busy_d, over, next_over, under, next_under;
    logic sign, next_sign, ovr_pend, next_ovr_pend, single, next_single;
    logic cmp_q, gate, count_en, clear_cnt, deint_start, load;
    logic ctrl_pin, next_ctrl_pin;
    logic [DIGITS-1:0][3:0] dcnt, next_dcnt, disp, next_disp;
    logic [DIGITS:0] carry;
    logic [2:0] idx, next_idx;
    logic [7:0] scnt, next_scnt, dig_len, strobe_at;
    logic strobing, next_strobing, blank, next_blank, next_latch_n;
    logic [DIGITS-1:0] next_sel;
    logic [3:0] next_bcd;
    switch_type next_sw;
    logic [31:0] next_prdata;
    logic next_pslverr;

    // With the pin-connected bit clear the gate pin is ignored and reads as high, see RULE3.
    assign gate = ctrl_pin ? i_conversion_gate : 1'b1;
    // Display latches take the count on the first clock after busy has fallen, see RULE15.
    assign load = busy_d & ~busy;

    // Phase sequencer: auto zero, integrate, deintegrate, integrator zero, see RULE1.
    always_comb begin
        next_phase = phase;
        next_ph_cnt = ph_cnt + 16'h0001;
        next_el_cnt = el_cnt + 16'h0001;
        next_az_len = az_len;
        next_busy = busy;
        next_over = over;
        next_under = under;
        next_sign = sign;
        next_ovr_pend = ovr_pend;
        next_single = single;
        next_gate_cnt = 8'h00;
        count_en = 1'b0;
        clear_cnt = 1'b0;
        deint_start = 1'b0;
        unique case (phase)
            PH_HOLD: begin
                // Only a pulse seen while holding can start a cycle, see RULE7.
                next_ph_cnt = 16'h0000;
                next_gate_cnt = (gate && gate_cnt != 8'hff) ? gate_cnt + 8'h01 : (gate ? gate_cnt : 8'h00);
                if (gate && gate_cnt >= GATE_MIN_CYC - 8'h01) begin // see RULE6
                    next_phase = PH_AZ;
                    next_az_len = AUTO_ZERO_CLOCKS; // see RULE8
                    next_single = 1'b1;
                end
            end
            PH_AZ: begin
                if (ph_cnt == az_len - 16'h0001) begin
                    next_phase = PH_INT;
                    next_ph_cnt = 16'h0000;
                    next_el_cnt = 16'h0000;
                    next_busy = 1'b1; // see RULE13
                    next_under = 1'b0; // see RULE18
                    next_single = 1'b0;
                    clear_cnt = 1'b1;
                end
            end
            PH_INT: begin
                if (ph_cnt == INTEGRATE_CLOCKS - 16'h0001) begin
                    next_phase = PH_DEINT;
                    next_ph_cnt = 16'h0000;
                    next_sign = cmp_q; // see RULE19
                    next_over = 1'b0; // see RULE17
                    deint_start = 1'b1;
                end
            end
            PH_DEINT: begin
                // The first clock is not counted, which makes up for the comparator sample delay.
                if (ph_cnt != 16'h0000) begin
                    if (cmp_q != sign) begin // see RULE23
                        next_phase = PH_IZ;
                        next_ph_cnt = 16'h0000;
                        next_busy = 1'b0; // see RULE13
                        next_ovr_pend = 1'b0;
                        next_under = (bin_cnt <= UNDER_LIMIT); // see RULE18
                    end else if (bin_cnt == FULL_SCALE) begin // see RULE16
                        next_phase = PH_IZ;
                        next_ph_cnt = 16'h0000;
                        next_busy = 1'b0; // see RULE14
                        next_over = 1'b1; // see RULE17
                        next_ovr_pend = 1'b1;
                    end else begin
                        count_en = 1'b1;
                    end
                end
            end
            PH_IZ: begin
                if (ph_cnt == (ovr_pend ? OVER_ZERO_CLOCKS : INT_ZERO_CLOCKS) - 16'h0001) begin // see RULE2
                    next_ph_cnt = 16'h0000;
                    // Auto zero absorbs the slack so that cycles start on a fixed period, see RULE4.
                    next_az_len = CYCLE_CLOCKS - (el_cnt + 16'h0001);
                    next_phase = gate ? PH_AZ : PH_HOLD; // see RULE5
                end
            end
            default: begin
                next_phase = PH_HOLD;
            end
        endcase
    end

    // Switch controls follow the phase that is being entered.
    always_comb begin
        next_sw.auto_zero = (next_phase == PH_AZ);
        next_sw.signal_int = (next_phase == PH_INT);
        next_sw.ref_int = (next_phase == PH_DEINT);
        next_sw.int_zero = (next_phase == PH_IZ);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            phase <= PH_AZ;
            ph_cnt <= 16'h0000;
            el_cnt <= 16'h0000;
            az_len <= AUTO_ZERO_CLOCKS;
            gate_cnt <= 8'h00;
            busy <= 1'b0;
            busy_d <= 1'b0;
            over <= 1'b0;
            under <= 1'b0;
            sign <= 1'b0;
            ovr_pend <= 1'b0;
            single <= 1'b1;
            cmp_q <= 1'b0;
            o_switches <= '0;
        end else begin
            phase <= next_phase;
            ph_cnt <= next_ph_cnt;
            el_cnt <= next_el_cnt;
            az_len <= next_az_len;
            gate_cnt <= next_gate_cnt;
            busy <= next_busy;
            busy_d <= busy;
            over <= next_over;
            under <= next_under;
            sign <= next_sign;
            ovr_pend <= next_ovr_pend;
            single <= next_single;
            cmp_q <= i_comparator; // see RULE23
            o_switches <= next_sw;
        end
    end

    assign o_busy = busy;
    assign o_input_above_full_scale = over;
    assign o_input_below_tenth_scale = under;
    assign o_sign_flag = sign;

    // Deintegration counter, kept in binary for limits and in BCD for the display.
    assign next_bin_cnt = clear_cnt ? 16'h0000 : (count_en ? bin_cnt + 16'h0001 : bin_cnt);
    assign carry[0] = count_en;
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : gen_digit
            assign carry[g+1] = carry[g] & (dcnt[g] == BCD_NINE);
            assign next_dcnt[g] = clear_cnt ? 4'h0 :
                (carry[g] ? ((dcnt[g] == BCD_NINE) ? 4'h0 : dcnt[g] + 4'h1) : dcnt[g]);
        end
    endgenerate
    assign next_disp = load ? dcnt : disp; // see RULE15

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            bin_cnt <= 16'h0000;
            dcnt <= '0;
            disp <= '0;
        end else begin
            bin_cnt <= next_bin_cnt;
            dcnt <= next_dcnt;
            disp <= next_disp;
        end
    end

    // Digit scan: restarts at each measurement end, repeats for refresh afterwards.
    assign dig_len = (idx == MSD_IDX) ? MSD_CLOCKS : DIGIT_CLOCKS; // see RULE10
    assign strobe_at = (idx == MSD_IDX) ? MSD_STROBE_AT : DIGIT_STROBE_AT; // see RULE11
    always_comb begin
        next_idx = idx;
        next_scnt = scnt + 8'h01;
        next_strobing = strobing;
        next_blank = blank;
        next_latch_n = 1'b1;
        if (load) begin
            next_idx = MSD_IDX;
            next_scnt = 8'h00;
            next_strobing = 1'b1;
        end else begin
            // The pulse is registered, so the match comes one count early to fall on the stated clock.
            if (strobing && scnt == strobe_at - 8'h01) begin
                next_latch_n = 1'b0; // see RULE9
            end
            if (scnt == dig_len - 8'h01) begin
                next_scnt = 8'h00;
                if (idx == LSD_IDX) begin
                    next_idx = MSD_IDX;
                    next_strobing = 1'b0; // see RULE12
                    // Blanking starts once the last strobed digit is out, so no strobe is lost.
                    next_blank = over; // see RULE20
                end else begin
                    next_idx = idx - 3'h1;
                end
            end
        end
        if (deint_start) begin
            next_blank = 1'b0; // see RULE20
        end
        next_sel = next_blank ? '0 : DIGITS'(1) << next_idx;
        // Data are registered with the selects so both change on the same edge, see RULE21.
        next_bcd = next_over ? 4'h0 : next_disp[next_idx]; // see RULE22
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            idx <= MSD_IDX;
            scnt <= 8'h00;
            strobing <= 1'b0;
            blank <= 1'b0;
            o_digit_latch_pulse_n <= 1'b1;
            o_digit_select <= '0;
            o_bcd <= 4'h0;
        end else begin
            idx <= next_idx;
            scnt <= next_scnt;
            strobing <= next_strobing;
            blank <= next_blank;
            o_digit_latch_pulse_n <= next_latch_n;
            o_digit_select <= next_sel;
            o_bcd <= next_bcd;
        end
    end

    // APB slave: read data is fetched in the setup cycle, so every access takes no wait state.
    assign o_pready = 1'b1;
    always_comb begin
        next_ctrl_pin = ctrl_pin;
        next_prdata = o_prdata;
        next_pslverr = o_pslverr;
        if (i_psel && !i_penable) begin
            next_pslverr = 1'b0;
            unique case (i_paddr)
                ADDR_CTRL: next_prdata = {31'h0, ctrl_pin};
                ADDR_STATUS: next_prdata = {24'h0, 1'b0, phase, sign, under, over, busy};
                ADDR_RESULT: next_prdata = {12'h000, disp};
                default: begin
                    next_prdata = 32'h0000_0000;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        if (i_psel && i_penable && i_pwrite && i_paddr == ADDR_CTRL) begin
            next_ctrl_pin = i_pwdata[CTRL_PIN_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ctrl_pin <= CTRL_RESET;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            ctrl_pin <= next_ctrl_pin;
            o_prdata <= next_prdata;
            o_pslverr <= next_pslverr;
        end
    end

    // Checks on the sequencer and the scan.
    iz_length_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE2
        (phase == PH_IZ && next_phase != PH_IZ)
        |-> ph_cnt == (ovr_pend ? OVER_ZERO_CLOCKS : INT_ZERO_CLOCKS) - 16'h0001)
        else $error("Integrator zero phase has the wrong length.");
    start_az_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE8
        (phase == PH_AZ && single && next_phase == PH_INT) |-> ph_cnt == AUTO_ZERO_CLOCKS - 16'h0001)
        else $error("Auto zero after a single start has the wrong length.");
    latch_in_select_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE9
        !o_digit_latch_pulse_n |-> (o_digit_select != '0) && $past(o_digit_select) == o_digit_select)
        else $error("Latch pulse outside a digit select.");
    busy_rise_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE13
        $rose(o_busy) |-> phase == PH_INT && ph_cnt == 16'h0000 && $past(phase) == PH_AZ)
        else $error("Busy rose outside the start of integration.");
    busy_az_low_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE13
        phase == PH_AZ |-> !o_busy)
        else $error("Busy high during auto zero.");
    crossing_end_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE23
        (phase == PH_DEINT && ph_cnt != 16'h0000 && cmp_q != sign) |=> !o_busy && phase == PH_IZ)
        else $error("Crossing did not end deintegration on the next edge.");
    deint_limit_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE16
        phase == PH_DEINT |-> bin_cnt <= FULL_SCALE)
        else $error("Deintegration count passed full scale.");
    over_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE17
        (phase == PH_DEINT && $past(phase) == PH_INT) |-> !o_input_above_full_scale)
        else $error("Overrange flag not cleared at deintegration start.");
    over_bcd_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE22
        (o_input_above_full_scale && $past(o_input_above_full_scale)) |-> o_bcd == 4'h0)
        else $error("BCD data not zero during overrange.");
    select_onehot_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // see RULE21
        $onehot0(o_digit_select) && (o_digit_select == '0 || o_bcd == (over ? 4'h0 : disp[idx])))
        else $error("Select and data out of step.");
endmodule
`default_nettype wire

/* File: verification/dsadc_receiver.sv */
// Receiver model that takes multiplexed BCD digits as each latch pulse ends.
`default_nettype none
module dsadc_receiver (
    input wire logic i_clk,
    input wire logic [4:0] i_digit_select,
    input wire logic [3:0] i_bcd,
    input wire logic i_digit_latch_pulse_n,
    output logic [19:0] o_value,
    output logic [7:0] o_strobes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_n;
    // The model has no reset of its own, so it starts from a known state.
    initial begin
        o_value = 20'h00000;
        o_strobes = 8'h00;
        last_n = 1'b1;
    end
    // Capture at the edge after the one that ends the pulse, while the digit is still selected.
    always @(posedge i_clk) begin
        if (last_n === 1'b0 && i_digit_latch_pulse_n === 1'b1) begin
            for (int d = 0; d < 5; d++) begin
                if (i_digit_select[d]) o_value[d * 4 +: 4] <= i_bcd;
            end
            o_strobes <= o_strobes + 8'h01;
        end
        last_n <= i_digit_latch_pulse_n;
    end
endmodule
`default_nettype wire

/* File: verification/dsadc_sequencer_tb.sv */
// Self-checking bench of the converter sequencer.
`default_nettype none
module dsadc_sequencer_tb import dsadc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // Shortened cycle lengths keep the run short, overrange integrator zero included; the normal integrator zero and digit scan timing stay at full length.
    localparam logic [15:0] CYC = 16'h057a;
    localparam logic [15:0] AZ = 16'h0065;
    localparam logic [15:0] INTG = 16'h0064;
    localparam logic [15:0] FS = 16'h00c8;
    localparam logic [15:0] OZ = 16'h003e;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic gate = 1'b0;
    logic cmp = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, busy, over, under, sign, latch_n;
    logic [31:0] prdata;
    switch_type sw;
    logic [4:0] dsel;
    logic [3:0] bcd;
    logic [8:0] mon;
    logic [19:0] rx_value;
    logic [7:0] rx_strobes;
    int fail_count = 0;
    int cmp_count = 0;

    // Selects and phase switches side by side, so one wait task serves both.
    assign mon = {dsel, sw};
    always #5 clk = ~clk;

    dsadc_sequencer #(.CYCLE_CLOCKS(CYC), .AUTO_ZERO_CLOCKS(AZ), .INTEGRATE_CLOCKS(INTG),
        .FULL_SCALE(FS), .OVER_ZERO_CLOCKS(OZ)) uut (.i_clk(clk), .i_nrst(nrst), .i_conversion_gate(gate),
        .i_comparator(cmp), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_switches(sw),
        .o_busy(busy), .o_input_above_full_scale(over), .o_input_below_tenth_scale(under),
        .o_sign_flag(sign), .o_digit_select(dsel), .o_bcd(bcd), .o_digit_latch_pulse_n(latch_n));
    dsadc_receiver rx (.i_clk(clk), .i_digit_select(dsel), .i_bcd(bcd), .i_digit_latch_pulse_n(latch_n),
        .o_value(rx_value), .o_strobes(rx_strobes));

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", w, x, g);
        end
    endtask
    task automatic stall;
        fail_count++;
        $display("wrong value wait expected done seen timeout");
        print_verdict();
    endtask
    // Outputs are looked at one nanosecond after the edge, once its updates have landed.
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    task automatic wait_for(input int b, input logic v);
        int n;
        for (n = 0; n < 9000 && mon[b] !== v; n++) step();
        if (n == 9000) stall();
    endtask
    task automatic plen(input int b, output int n);
        wait_for(b, 1'b1);
        for (n = 0; n < 9000 && mon[b] === 1'b1; n++) step();
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) stall();
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic digit(input int d, input int off, input logic [3:0] nib, input int slack);
        int w;
        int lo;
        wait_for(4 + d, 1'b1);
        lo = -1;
        chk("bcd digit", 1, bcd >= nib && bcd <= nib + slack);
        for (w = 0; w < 400 && mon[4 + d] === 1'b1; w++) begin
            if (latch_n === 1'b0) lo = w;
            step();
        end
        chk("select width", d == 4 ? 201 : 200, w);
        chk("latch offset", off, lo);
    endtask
    // The comparator flips k clocks into deintegration; k of zero never flips, giving overrange.
    task automatic conv(input logic pol, input int k, input logic [19:0] lo, input logic azchk);
        int n;
        int z;
        logic [7:0] s0;
        @(posedge clk);
        cmp <= pol;
        #1;
        plen(3, n);
        if (azchk) chk("auto zero length", AZ, n);
        s0 = rx_strobes;
        chk("busy in integrate", 1, busy);
        chk("underrange cleared", 0, under);
        plen(2, n);
        chk("integrate length", INTG, n);
        chk("deintegrate next", 1, mon[1]);
        chk("sign", pol, sign);
        chk("overrange cleared", 0, over);
        for (n = 1; n < 400; n++) begin
            @(posedge clk);
            if (n == k) cmp <= ~pol;
            #1;
            if (mon[1] !== 1'b1) break;
        end
        if (k != 0) chk("deintegrate length", k + 2, n);
        chk("zero phase next", 1, mon[0]);
        chk("busy after end", 0, busy);
        chk("overrange", k == 0, over);
        if (k != 0) chk("underrange", 1, under);
        fork
            begin
                plen(0, z);
                chk("zero phase length", k == 0 ? OZ : INT_ZERO_CLOCKS, z);
            end
            begin
                step();
                chk("msd after busy", 5'h10, dsel);
                for (int d = 4; d >= 0; d--) digit(d, d == 4 ? 101 : 100, lo[d * 4 +: 4], d == 0 ? 2 : 0);
            end
        join
        chk("strobes per cycle", 5, rx_strobes - s0);
        chk("captured digits", lo[19:4], rx_value[19:4]);
        if (k != 0) digit(4, -1, lo[19:16], 0);
    endtask
    task automatic idle(input int c, input logic sel);
        int bad = 0;
        repeat (c) begin
            if (sel ? dsel !== 5'h00 : (mon[3:0] !== 4'h0 || busy !== 1'b0)) bad++;
            step();
            if (sel && mon[2] === 1'b1) break;
        end
        chk("idle samples", 0, bad);
    endtask
    task automatic gate_pulse(input int c);
        @(posedge clk);
        gate <= 1'b1;
        repeat (c) @(posedge clk);
        gate <= 1'b0;
    endtask

    // Main sequence: the gate input stays low, yet conversion runs until the pin is enabled.
    initial begin
        logic [31:0] r;
        logic e;
        int n;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        step();
        chk("latch idle after reset", 1, latch_n);
        apb(1'b0, ADDR_CTRL, 32'h0, r, e);
        chk("control reset", {31'h0, CTRL_RESET}, r);
        apb(1'b0, 12'hffc, 32'h0, r, e);
        chk("unmapped error", 1, e);
        chk("unmapped data", 0, r);
        conv(1'b1, 58, 20'h00057, 1'b0);
        apb(1'b0, ADDR_RESULT, 32'h0, r, e);
        chk("result register", 16'h0005, r[19:4]);
        wait_for(3, 1'b0);
        wait_for(3, 1'b1);
        plen(3, n);
        for (r = n; r < 5000 && mon[3] !== 1'b1; r++) step();
        chk("cycle period", CYC, r);
        conv(1'b1, 0, 20'h00000, 1'b0);
        idle(3000, 1'b1);
        conv(1'b0, 44, 20'h00043, 1'b0);
        wait_for(2, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h1, r, e);
        apb(1'b0, ADDR_CTRL, 32'h0, r, e);
        chk("control readback", 1, r);
        gate_pulse(40);
        wait_for(0, 1'b1);
        wait_for(0, 1'b0);
        idle(1500, 1'b0);
        gate_pulse(20);
        idle(300, 1'b0);
        apb(1'b0, ADDR_STATUS, 32'h0, r, e);
        chk("status phase", 0, r[6:4]);
        fork
            gate_pulse(40);
            conv(1'b1, 24, 20'h00023, 1'b1);
        join
        idle(500, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
